// [hdl/dchw_pkg.sv]
// Constants and types for the disk controller host word interface
// Functional notes
// - Eight consecutive word addresses from a switch-selected base; drive status word first.
// - Transfer address takes 15 low bits from low word, 5 high from select word.
// - Byte count word gives the bytes moved by the operation.
// - Sector and cylinder words are held for the next operation.
// - Writing controller status with bit 0 clear starts the operation; written last.
// - New control words replace old status; drive status fields ignore host writes.
// - Writes during an operation complete normally but change nothing.
// - Reads while busy return a substitute status word with bit 0 clear.
// - Controller status bit 0 reads zero busy, one idle and command-ready.
// - Restore and seek report idle early; drive completion is signalled separately.
// - Interrupt enable set at start raises a completion interrupt on return to idle.
// - Clearing interrupt enable or completion bit clears the completion interrupt.
// - Four per-unit attention bits, set on ready or seek error, any selection.
// - Drive status word bits 8-11 attention, bits 12-15 host attention masks.
// - Interrupt asserted when any unit has attention and mask both set.
// - Host owns the mask bits; only the device sets attention and drive status.
// - Drive interrupt needs controller idle; dropped when the host clears the mask.
// - Every idle to busy change clears all pending controller interrupts.
`default_nettype none
package dchw_pkg;

  // ****************************************************************
  // Word map
  // ****************************************************************
  localparam int         DCHW_ADDR_W       = 8;
  localparam int         DCHW_BASE_W       = 5;
  localparam int         DCHW_WORDS        = 8;
  localparam logic [2:0] DCHW_IDX_DRV_STAT = 3'h0;
  localparam logic [2:0] DCHW_IDX_CMD_HEAD = 3'h1;
  localparam logic [2:0] DCHW_IDX_SECTOR   = 3'h2;
  localparam logic [2:0] DCHW_IDX_CYLINDER = 3'h3;
  localparam logic [2:0] DCHW_IDX_BYTE_CNT = 3'h4;
  localparam logic [2:0] DCHW_IDX_ADDR_LO  = 3'h5;
  localparam logic [2:0] DCHW_IDX_SEL_HI   = 3'h6;
  localparam logic [2:0] DCHW_IDX_CTL_STAT = 3'h7;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int DCHW_DSTAT_W    = 8;   // Drive status bits 0..7
  localparam int DCHW_ATTN_LSB   = 8;   // Attention flags 8..11
  localparam int DCHW_MASK_LSB   = 12;  // Attention masks 12..15
  localparam int DCHW_UNITS      = 4;
  localparam int DCHW_CS_IDLE    = 0;
  localparam int DCHW_CS_IE      = 1;
  localparam int DCHW_CS_CC      = 2;
  localparam int DCHW_CS_ST_LSB  = 3;
  localparam int DCHW_ALO_W      = 15;
  localparam int DCHW_AHI_W      = 5;
  localparam int DCHW_PIN_W      = DCHW_DSTAT_W + DCHW_UNITS + DCHW_BASE_W;

  // ****************************************************************
  // Reset and substitute values
  // ****************************************************************
  localparam logic [15:0] DCHW_CS_RST     = 16'h0001;
  localparam logic [15:0] DCHW_WORD_RST   = 16'h0000;
  localparam logic [15:0] DCHW_BUSY_READ  = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    DCHW_ST_IDLE = 2'b01,
    DCHW_ST_BUSY = 2'b10
  } dchw_op_t;

  typedef struct packed {
    logic                   req;
    logic                   we;
    logic [DCHW_ADDR_W-1:0] addr;
    logic [15:0]            wdata;
  } dchw_bus_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } dchw_bus_rsp_t;

  typedef struct packed {
    logic [15:0] command_head;
    logic [15:0] sector;
    logic [15:0] cylinder;
    logic [15:0] byte_count;
    logic [19:0] mem_addr;
    logic [15:0] select_word;
    logic [15:0] ctl_word;
  } dchw_params_t;

  typedef struct packed {
    dchw_op_t                   op;
    logic [DCHW_PIN_W-1:0]      s1;
    logic [DCHW_PIN_W-1:0]      s2;
    logic [DCHW_PIN_W-1:0]      s3;
    logic [DCHW_PIN_W-1:0]      pins;
    logic [DCHW_WORDS-1:0][15:0] words;
    logic                       ie_run;
    logic                       pend_cc;
    logic                       irq;
    logic                       start;
    dchw_bus_rsp_t              rsp;
    dchw_params_t               params;
  } dchw_state_t;

endpackage
`default_nettype wire

// [hdl/dchw_host_words.sv]
// Host word interface of the disk controller: decode, words, interrupts
`default_nettype none
module dchw_host_words (
  input  wire logic                            mclk,         // System clock
  input  wire logic                            rst_n,        // Synchronous reset, low
  input  wire dchw_pkg::dchw_bus_req_t         bus_req,      // Host word access
  output var  dchw_pkg::dchw_bus_rsp_t         bus_rsp,      // Access answer
  input  wire logic [dchw_pkg::DCHW_BASE_W-1:0] base_sw,     // Base address switch
  input  wire logic [dchw_pkg::DCHW_DSTAT_W-1:0] drv_status, // Selected drive status pins
  input  wire logic [dchw_pkg::DCHW_UNITS-1:0] drv_attn,     // Per-unit attention pins
  input  wire logic                            op_done,      // Engine finished, pulse
  input  wire logic [15:0]                     op_status,    // Engine final status
  output var  logic                            op_start,     // Start pulse to engine
  output var  logic                            op_busy,      // Operation running
  output var  dchw_pkg::dchw_params_t          op_params,    // Latched operation words
  output var  logic                            irq           // Interrupt to host
);
  import dchw_pkg::*;

  dchw_state_t st_reg;
  dchw_state_t st_next;

  // ****************************************************************
  // Functions
  // ****************************************************************

  // Per-bit filter: take a bit once stages two and three agree
  function automatic logic [DCHW_PIN_W-1:0] pin_filter(
    input logic [DCHW_PIN_W-1:0] a,
    input logic [DCHW_PIN_W-1:0] b,
    input logic [DCHW_PIN_W-1:0] held
  );
    logic [DCHW_PIN_W-1:0] diff;
    diff = a ^ b;
    return (~diff & a) | (diff & held);
  endfunction

  // Address hit on the eight-word window
  function automatic logic word_hit(
    input logic [DCHW_ADDR_W-1:0] addr,
    input logic [DCHW_BASE_W-1:0] base
  );
    return addr[DCHW_ADDR_W-1:3] == base;
  endfunction

  // Masked attention condition
  function automatic logic attn_pending(
    input logic [DCHW_PIN_W-1:0] pins,
    input logic [15:0]           mask_word
  );
    logic [DCHW_UNITS-1:0] attn;
    logic [DCHW_UNITS-1:0] mask;
    attn = pins[DCHW_DSTAT_W +: DCHW_UNITS];
    mask = mask_word[DCHW_MASK_LSB +: DCHW_UNITS];
    return |(attn & mask);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic                     hit;
  logic                     idle;
  logic [2:0]               idx;
  logic [DCHW_UNITS-1:0]    attn_now;
  logic [DCHW_DSTAT_W-1:0]  dstat_now;
  logic [DCHW_BASE_W-1:0]   base_now;
  logic [15:0]              rd_word;

  always_comb begin
    st_next   = st_reg;
    idle      = (st_reg.op == DCHW_ST_IDLE);
    dstat_now = st_reg.pins[0 +: DCHW_DSTAT_W];
    attn_now  = st_reg.pins[DCHW_DSTAT_W +: DCHW_UNITS];
    base_now  = st_reg.pins[DCHW_DSTAT_W+DCHW_UNITS +: DCHW_BASE_W];
    idx       = bus_req.addr[2:0];
    hit       = bus_req.req && word_hit(bus_req.addr, base_now);
    st_next.start = 1'b0;

    // Pin synchronisers, three stages then agreement filter
    // base switch, per-unit attention and drive status pins
    st_next.s1   = {base_sw, drv_attn, drv_status};
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    st_next.pins = pin_filter(st_reg.s2, st_reg.s3, st_reg.pins);

    // Read view of the selected word
    rd_word = st_reg.words[idx];
    if (idx == DCHW_IDX_DRV_STAT) begin
      rd_word = {st_reg.words[DCHW_IDX_DRV_STAT][DCHW_MASK_LSB +: DCHW_UNITS], attn_now, dstat_now};
    end
    if (!idle) begin
      rd_word = DCHW_BUSY_READ;
    end
    st_next.rsp.ack   = hit;
    st_next.rsp.rdata = hit && !bus_req.we ? rd_word : DCHW_WORD_RST;

    // writes during an operation are acknowledged and dropped
    if (hit && bus_req.we && idle) begin
      unique case (idx)
        DCHW_IDX_DRV_STAT: begin
          // only the mask field takes host data
          // host owns masks, drive owns the rest
          st_next.words[DCHW_IDX_DRV_STAT] = DCHW_WORD_RST;
          st_next.words[DCHW_IDX_DRV_STAT][DCHW_MASK_LSB +: DCHW_UNITS] =
            bus_req.wdata[DCHW_MASK_LSB +: DCHW_UNITS];
        end
        DCHW_IDX_CTL_STAT: begin
          if (!bus_req.wdata[DCHW_CS_IDLE]) begin
            // start on bit 0 written clear
            st_next.op     = DCHW_ST_BUSY;
            st_next.start  = 1'b1;
            st_next.ie_run = bus_req.wdata[DCHW_CS_IE];
            st_next.words[DCHW_IDX_CTL_STAT] = bus_req.wdata;
            // idle to busy clears pending interrupts
            st_next.pend_cc = 1'b0;
            st_next.params.mem_addr = {st_reg.words[DCHW_IDX_SEL_HI][0 +: DCHW_AHI_W],
                                       st_reg.words[DCHW_IDX_ADDR_LO][0 +: DCHW_ALO_W]};
            st_next.params.byte_count   = st_reg.words[DCHW_IDX_BYTE_CNT];
            // sector and cylinder for this operation
            st_next.params.sector       = st_reg.words[DCHW_IDX_SECTOR];
            st_next.params.cylinder     = st_reg.words[DCHW_IDX_CYLINDER];
            st_next.params.command_head = st_reg.words[DCHW_IDX_CMD_HEAD];
            st_next.params.select_word  = st_reg.words[DCHW_IDX_SEL_HI];
            st_next.params.ctl_word     = bus_req.wdata;
          end else begin
            // new control word replaces old status, idle bit kept
            st_next.words[DCHW_IDX_CTL_STAT] = bus_req.wdata;
            // clearing enable or completion drops the interrupt
            if (!bus_req.wdata[DCHW_CS_IE] || !bus_req.wdata[DCHW_CS_CC]) begin
              st_next.pend_cc = 1'b0;
            end
          end
        end
        default: begin
          st_next.words[idx] = bus_req.wdata;
        end
      endcase
    end

    // Engine completion: back to idle with its status
    if (!idle && op_done) begin
      st_next.op = DCHW_ST_IDLE;
      // idle reported regardless of drive motion
      st_next.words[DCHW_IDX_CTL_STAT] = {op_status[15:DCHW_CS_ST_LSB], 1'b1, st_reg.ie_run, 1'b1};
      // completion interrupt if enabled at start
      st_next.pend_cc = st_reg.ie_run;
    end

    st_next.irq = st_next.pend_cc ||
                  ((st_next.op == DCHW_ST_IDLE) &&
                   attn_pending(st_next.pins, st_next.words[DCHW_IDX_DRV_STAT]));
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // idle, status bit 0 set, interrupt low after reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg        <= '0;
      st_reg.op     <= DCHW_ST_IDLE;
      st_reg.words[DCHW_IDX_CTL_STAT] <= DCHW_CS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign bus_rsp   = st_reg.rsp;
  assign op_start  = st_reg.start;
  assign op_busy   = (st_reg.op == DCHW_ST_BUSY);
  assign op_params = st_reg.params;
  assign irq       = st_reg.irq;

endmodule
`default_nettype wire

// [tb/dchw_host.sv]
// Host processor model issuing word accesses to the controller
`default_nettype none
module dchw_host #(
  parameter logic [4:0] BASE = 5'h00 // Switch-selected base
) (
  input  wire dchw_pkg::dchw_bus_rsp_t bus_rsp, // Access answer
  input  wire logic                    mclk,    // System clock
  output var  dchw_pkg::dchw_bus_req_t bus_req  // Word access
);
  timeunit 1ns;
  timeprecision 1ps;
  import dchw_pkg::*;
  int   to_cnt = 0;
  logic expect_miss = 1'b0; // Set by the bench when no answer is wanted
  logic last_ack = 1'b0;    // Last access was answered
  initial bus_req = '0;
  // One access: request for one cycle, take the answer with ack
  task acc(input logic we, input logic [2:0] idx, input logic [15:0] wd, output logic [15:0] q);
    int n;
    @(negedge mclk);
    bus_req <= '{1'b1, we, {BASE, idx}, wd};
    @(negedge mclk);
    bus_req.req <= 1'b0;
    n = 0;
    while (bus_rsp.ack !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    q = bus_rsp.rdata;
    last_ack = (n < 4);
    if (n == 4 && !expect_miss) to_cnt++;
  endtask
  task wr(input logic [2:0] idx, input logic [15:0] wd);
    logic [15:0] q;
    acc(1'b1, idx, wd, q);
  endtask
  task rd(input logic [2:0] idx, output logic [15:0] q);
    acc(1'b0, idx, 16'h0000, q);
  endtask
  task start(input logic [15:0] ctl);
    logic [15:0] q;
    rd(DCHW_IDX_CTL_STAT, q);
    if (q[DCHW_CS_IDLE]) wr(DCHW_IDX_CTL_STAT, ctl);
    else to_cnt++;
  endtask
  task poll_idle(output logic [15:0] q);
    int n;
    n = 0;
    q = 16'h0000;
    while (q[0] !== 1'b1 && n < 8) begin
      rd(DCHW_IDX_CTL_STAT, q);
      n++;
    end
  endtask
endmodule
`default_nettype wire

// [tb/dchw_host_words_asserts.sv]
// Port checker for the host word interface
`default_nettype none
module dchw_host_words_chk (
  input wire logic                            mclk,       // System clock
  input wire logic                            rst_n,      // Reset, low
  input wire dchw_pkg::dchw_bus_req_t         bus_req,    // Host access
  input wire dchw_pkg::dchw_bus_rsp_t         bus_rsp,    // Access answer
  input wire logic [dchw_pkg::DCHW_BASE_W-1:0] base_sw,   // Base switch
  input wire logic                            op_done,    // Engine done
  input wire logic                            op_start,   // Start pulse
  input wire logic                            op_busy,    // Busy level
  input wire logic                            irq         // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  import dchw_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Idle control write that may start an operation
  wire logic go = bus_req.req && bus_req.we && bus_req.addr == {base_sw, DCHW_IDX_CTL_STAT} && !bus_req.wdata[0]
                  && !op_busy;
  property p_start_cause; op_start |-> $past(go); endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without control write");
  property p_start_one; op_start |=> !op_start; endproperty
  a_start_one: assert property (p_start_one) else $error("second start while busy");
  property p_start_busy; op_start |-> op_busy; endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_busy_hold; op_busy && !op_done |=> op_busy; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
  property p_done_cause; $fell(op_busy) |-> $past(op_done); endproperty
  a_done_cause: assert property (p_done_cause) else $error("idle without done");
  property p_busy_read; $past(op_busy) && bus_rsp.ack |-> bus_rsp.rdata == DCHW_BUSY_READ; endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read not substitute");
  property p_irq_busy; op_busy && $past(op_busy) |-> !irq; endproperty
  a_irq_busy: assert property (p_irq_busy) else $error("interrupt while busy");
  property p_stray_ack; !$past(bus_req.req) |-> !bus_rsp.ack && bus_rsp.rdata == 16'h0000; endproperty
  a_stray_ack: assert property (p_stray_ack) else $error("answer without request");
  c_start: cover property (op_start);
  c_irq: cover property ($rose(irq));
  c_busy_read: cover property ($past(op_busy) && bus_rsp.ack);
endmodule
bind dchw_host_words dchw_host_words_chk u_chk (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
  .bus_rsp(bus_rsp), .base_sw(base_sw), .op_done(op_done), .op_start(op_start), .op_busy(op_busy), .irq(irq));
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking bench for the disk controller host word interface
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dchw_pkg::*;
  localparam logic [4:0] BASE = 5'h0a;
  typedef struct packed {logic [2:0] idx; logic [15:0] wd; logic [15:0] ex;} dchw_row_t;
  logic          mclk = 1'b0;
  logic          rst_n = 1'b0;
  logic [7:0]    drv_status = 8'h5a;
  logic [3:0]    drv_attn = 4'h0;
  logic [4:0]    base_sw = BASE;
  logic          op_done = 1'b0;
  logic [15:0]   op_status = 16'hfff8;
  logic          op_start;
  logic          op_busy;
  logic          irq;
  logic [15:0]   d;
  dchw_bus_req_t bus_req;
  dchw_bus_rsp_t bus_rsp;
  dchw_params_t  op_params;
  int            failures = 0;
  int            checks = 0;
  // Word, written value, expected read
  dchw_row_t rows [7] = '{'{3'h1, 16'h1234, 16'h1234}, '{3'h2, 16'ha5a5, 16'ha5a5}, '{3'h3, 16'h0f0f, 16'h0f0f},
    '{3'h4, 16'h0200, 16'h0200}, '{3'h5, 16'hc123, 16'hc123}, '{3'h6, 16'h001f, 16'h001f},
    '{3'h0, 16'h3fff, 16'h305a}};
  always #20 mclk = ~mclk;
  dchw_host #(.BASE(BASE)) u_host (.bus_rsp(bus_rsp), .mclk(mclk), .bus_req(bus_req));
  dchw_host_words uut (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .bus_rsp(bus_rsp), .base_sw(base_sw),
    .drv_status(drv_status), .drv_attn(drv_attn), .op_done(op_done), .op_status(op_status),
    .op_start(op_start), .op_busy(op_busy), .op_params(op_params), .irq(irq));
  task chk(input logic [15:0] got, input logic [15:0] ex, input string what);
    checks++;
    if (got !== ex) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, ex);
    end
  endtask
  task wait_irq(input logic v);
    int n;
    n = 0;
    while (irq !== v && n < 12) begin
      @(negedge mclk);
      n++;
    end
    chk({15'h0000, irq}, {15'h0000, v}, "irq");
  endtask
  task finish_op;
    @(negedge mclk);
    op_done = 1'b1;
    @(negedge mclk);
    op_done = 1'b0;
  endtask
  task close_out;
    failures += u_host.to_cnt;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    failures++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    u_host.rd(DCHW_IDX_CTL_STAT, d);
    chk(d, DCHW_CS_RST, "idle after reset");
    wait_irq(1'b0);
    $display("reset test done");
    foreach (rows[i]) begin
      u_host.wr(rows[i].idx, rows[i].wd);
      u_host.rd(rows[i].idx, d);
      chk(d, rows[i].ex, "word readback");
    end
    $display("row tests done");
    // Moved base switch: the host window must get no answer
    base_sw = 5'h0b;
    repeat (8) @(negedge mclk);
    u_host.expect_miss = 1'b1;
    u_host.rd(DCHW_IDX_CTL_STAT, d);
    chk({15'h0000, u_host.last_ack}, 16'h0000, "off-window answer");
    u_host.expect_miss = 1'b0;
    base_sw = BASE;
    repeat (8) @(negedge mclk);
    $display("window test done");
    u_host.start(16'h0002);
    chk({15'h0000, op_start}, 16'h0001, "start pulse");
    chk({15'h0000, op_busy}, 16'h0001, "busy");
    chk(op_params.command_head, 16'h1234, "command word");
    chk(op_params.select_word, 16'h001f, "select word");
    chk(op_params.ctl_word, 16'h0002, "control word");
    chk(op_params.sector, 16'ha5a5, "sector");
    chk(op_params.cylinder, 16'h0f0f, "cylinder");
    chk(op_params.byte_count, 16'h0200, "count");
    chk(op_params.mem_addr[15:0], 16'hc123, "addr low");
    chk(op_params.mem_addr[19:4], 16'hfc12, "addr high");
    u_host.wr(DCHW_IDX_SECTOR, 16'h1111);
    u_host.rd(DCHW_IDX_SECTOR, d);
    chk(d, DCHW_BUSY_READ, "busy read");
    finish_op();
    wait_irq(1'b1);
    u_host.poll_idle(d);
    chk(d, 16'hffff, "status after done");
    u_host.rd(DCHW_IDX_SECTOR, d);
    chk(d, 16'ha5a5, "write while busy");
    u_host.wr(DCHW_IDX_CTL_STAT, 16'h0003);
    wait_irq(1'b0);
    $display("completion test done");
    u_host.wr(DCHW_IDX_DRV_STAT, 16'h0000);
    u_host.start(16'h0000);
    drv_attn = 4'h2;
    drv_status = 8'h58;
    finish_op();
    u_host.wr(DCHW_IDX_DRV_STAT, 16'h2000);
    wait_irq(1'b1);
    u_host.rd(DCHW_IDX_DRV_STAT, d);
    chk(d, 16'h2258, "attention word");
    chk({15'h0000, d[DCHW_ATTN_LSB + 1] && (!d[1] || d[5])}, 16'h0001, "drive done");
    u_host.start(16'h0000);
    wait_irq(1'b0);
    finish_op();
    wait_irq(1'b1);
    u_host.wr(DCHW_IDX_DRV_STAT, 16'h0000);
    wait_irq(1'b0);
    $display("attention test done");
    // Pending completion dropped by the next start, then reset mid-run
    u_host.start(16'h0002);
    finish_op();
    wait_irq(1'b1);
    u_host.start(16'h0002);
    wait_irq(1'b0);
    rst_n = 1'b0;
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    chk({15'h0000, op_busy}, 16'h0000, "busy after reset");
    repeat (8) @(negedge mclk);
    u_host.rd(DCHW_IDX_CTL_STAT, d);
    chk(d, DCHW_CS_RST, "idle after mid-run reset");
    wait_irq(1'b0);
    $display("mid-run reset test done");
    close_out();
  end
endmodule
`default_nettype wire
